// ==== hdl/scfg_consts.svh ====
`ifndef SCFG_CONSTS_SVH
`define SCFG_CONSTS_SVH
`define SCFG_OFF_SUBVEN 8'h2C
`define SCFG_OFF_SUBID 8'h2E
`define SCFG_OFF_CAP 8'h34
`define SCFG_OFF_INTLN 8'h3C
`define SCFG_OFF_PTIM 8'h40
`define SCFG_OFF_STIM 8'h42
`define SCFG_OFF_PWRHDR 8'h70
`define SCFG_OFF_PWRCAPS 8'h72
`define SCFG_OFF_PWRCTL 8'h74
`define SCFG_OFF_MSGHDR 8'h80
`define SCFG_OFF_MSGCTL 8'h82
`define SCFG_OFF_MSGADDR 8'h84
`define SCFG_OFF_MSGADDR_HI 8'h86
`define SCFG_OFF_MSGDATA 8'h88
`define SCFG_SUBCLASS_IDE 8'h01
`define SCFG_CAP_NORM 8'h80
`define SCFG_CAP_IDE 8'h70
`define SCFG_PNEXT_IDE 8'hB0
`define SCFG_PNEXT_NORM 8'hA8
`define SCFG_PM_CID 8'h01
`define SCFG_WAKE_NORM 5'h08
`define SCFG_WAKE_IDE 5'h00
`define SCFG_PM_VER 3'h3
`define SCFG_MSI_HDR 16'h7005
`define SCFG_MMC_NORM 3'h4
`define SCFG_MMC_IDE 3'h0
`define SCFG_VEC_PORT 3'h4
`define SCFG_NO_WAKE_RESET 1'h1
`define SCFG_BIT_DEC 15
`define SCFG_BIT_WSTS 15
`define SCFG_BIT_WEN 8
`endif

// ==== hdl/scfg_pkg.sv ====
package scfg_pkg;
   typedef enum logic [1:0] {SCFG_D0 = 2'h0, SCFG_D3HOT = 2'h3} scfg_pstate_t;
   typedef enum {SCFG_MSG_IDLE, SCFG_MSG_SEND} scfg_msg_t;
endpackage : scfg_pkg

// ==== hdl/scfg_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "scfg_consts.svh"
module scfg_regs (
   // Clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic FLR,
   // Configuration access
   input wire logic CFG_WR,
   input wire logic CFG_RD,
   input wire logic [7:0] CFG_ADDR,
   input wire logic [15:0] CFG_WDATA,
   output logic [15:0] CFG_RDATA,
   // Mode and chipset inputs
   input wire logic [7:0] STORAGE_SUBCLASS_CODE,
   input wire logic [3:0] CHIPSET_INTERRUPT_PIN_SELECT,
   // Events
   input wire logic WAKE_EVENT,
   input wire logic PORT_IRQ,
   input wire logic [2:0] PORT_NUM,
   // Outputs
   output logic PRIMARY_DECODE_ON,
   output logic SECONDARY_DECODE_ON,
   output logic INTX_ASSERT,
   output logic PME_ASSERT,
   output logic IO_MEM_ENABLE,
   output logic MSI_WR,
   output logic [31:0] MSI_ADDR,
   output logic [15:0] MSI_DATA
);
   ////////////////////////////////////////////////////////////////
   logic ide_mode;
   logic [15:0] subsystem_vendor_value;
   logic [15:0] subsystem_identifier_value;
   logic subven_done;
   logic subid_done;
   logic [7:0] interrupt_line_reg;
   logic [15:0] primary_channel_decode;
   logic [15:0] secondary_channel_decode;
   logic wake_request_status;
   logic wake_request_enable;
   scfg_pkg::scfg_pstate_t power_state_field;
   logic [2:0] vector_count_enable;
   logic message_interrupt_on;
   logic [29:0] msg_addr_hi;
   logic [15:0] message_data_value;
   logic [15:0] next_rdata;
   logic [15:0] msg_word;
   logic wr_ok;
   scfg_pkg::scfg_msg_t msg_state;

   assign ide_mode = (STORAGE_SUBCLASS_CODE == `SCFG_SUBCLASS_IDE);
   assign wr_ok = CFG_WR;

   ////////////////////////////////////////////////////////////////
   // Write-once identifiers, untouched by function reset
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         subsystem_vendor_value <= 16'h0000;
         subsystem_identifier_value <= 16'h0000;
         subven_done <= 1'b0;
         subid_done <= 1'b0;
      end else if (wr_ok) begin
         if (CFG_ADDR == `SCFG_OFF_SUBVEN && !subven_done) begin
            subsystem_vendor_value <= CFG_WDATA;
            subven_done <= 1'b1;
         end else if (CFG_ADDR == `SCFG_OFF_SUBID && !subid_done) begin
            subsystem_identifier_value <= CFG_WDATA;
            subid_done <= 1'b1;
         end
      end
   end

   // Plain RW registers
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         interrupt_line_reg <= 8'h00;
         primary_channel_decode <= 16'h0000;
         secondary_channel_decode <= 16'h0000;
      end else if (wr_ok) begin
         if (CFG_ADDR == `SCFG_OFF_INTLN) begin
            interrupt_line_reg <= CFG_WDATA[7:0];
         end else if (CFG_ADDR == `SCFG_OFF_PTIM) begin
            primary_channel_decode <= {CFG_WDATA[15], 15'h0000};
         end else if (CFG_ADDR == `SCFG_OFF_STIM) begin
            secondary_channel_decode <= {CFG_WDATA[15], 15'h0000};
         end
      end
   end

   // Decode enables drive the legacy and native decoders
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         PRIMARY_DECODE_ON <= 1'b0;
         SECONDARY_DECODE_ON <= 1'b0;
      end else begin
         PRIMARY_DECODE_ON <= primary_channel_decode[`SCFG_BIT_DEC];
         SECONDARY_DECODE_ON <= secondary_channel_decode[`SCFG_BIT_DEC];
      end
   end

   ////////////////////////////////////////////////////////////////
   // Power state; function reset returns to D0
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         power_state_field <= scfg_pkg::SCFG_D0;
      end else if (FLR) begin
         power_state_field <= scfg_pkg::SCFG_D0;
      end else if (wr_ok && CFG_ADDR == `SCFG_OFF_PWRCTL) begin
         // D1/D2 unsupported: such writes are ignored
         if (CFG_WDATA[1:0] == 2'h0) begin
            power_state_field <= scfg_pkg::SCFG_D0;
         end else if (CFG_WDATA[1:0] == 2'h3) begin
            power_state_field <= scfg_pkg::SCFG_D3HOT;
         end
      end
   end

   // Wake bits survive function reset; event set beats W1C clear
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         wake_request_status <= 1'b0;
         wake_request_enable <= 1'b0;
      end else if (ide_mode) begin
         wake_request_status <= 1'b0;
         wake_request_enable <= 1'b0;
      end else begin
         if (WAKE_EVENT) begin
            wake_request_status <= 1'b1;
         end else if (wr_ok && CFG_ADDR == `SCFG_OFF_PWRCTL && CFG_WDATA[`SCFG_BIT_WSTS]) begin
            wake_request_status <= 1'b0;
         end
         if (wr_ok && CFG_ADDR == `SCFG_OFF_PWRCTL) begin
            wake_request_enable <= CFG_WDATA[`SCFG_BIT_WEN];
         end
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         PME_ASSERT <= 1'b0;
         IO_MEM_ENABLE <= 1'b1;
      end else begin
         PME_ASSERT <= wake_request_status && wake_request_enable
                       && power_state_field == scfg_pkg::SCFG_D3HOT;
         IO_MEM_ENABLE <= power_state_field == scfg_pkg::SCFG_D0;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Message registers
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         vector_count_enable <= 3'h0;
         message_interrupt_on <= 1'b0;
         msg_addr_hi <= 30'h0;
         message_data_value <= 16'h0000;
      end else begin
         if (ide_mode) begin
            message_interrupt_on <= 1'b0;
         end else if (wr_ok && CFG_ADDR == `SCFG_OFF_MSGCTL) begin
            message_interrupt_on <= CFG_WDATA[0];
         end
         if (wr_ok && CFG_ADDR == `SCFG_OFF_MSGCTL) begin
            vector_count_enable <= CFG_WDATA[6:4];
         end
         if (wr_ok && CFG_ADDR == `SCFG_OFF_MSGADDR) begin
            msg_addr_hi <= {msg_addr_hi[29:14], CFG_WDATA[15:2]};
         end else if (wr_ok && CFG_ADDR == `SCFG_OFF_MSGADDR_HI) begin
            msg_addr_hi <= {CFG_WDATA, msg_addr_hi[13:0]};
         end
         if (wr_ok && CFG_ADDR == `SCFG_OFF_MSGDATA) begin
            message_data_value <= CFG_WDATA;
         end
      end
   end

   // Compose message word by vector mode
   always_comb begin
      if (vector_count_enable == `SCFG_VEC_PORT) begin
         msg_word = {message_data_value[15:3], PORT_NUM};
      end else if (vector_count_enable == 3'h2) begin
         msg_word = {message_data_value[15:2], PORT_NUM[1:0]};
      end else if (vector_count_enable == 3'h1) begin
         msg_word = {message_data_value[15:1], PORT_NUM[0]};
      end else begin
         msg_word = message_data_value;
      end
   end

   // One write per event; D3hot blocks all interrupt signalling
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         msg_state <= scfg_pkg::SCFG_MSG_IDLE;
         MSI_WR <= 1'b0;
         MSI_ADDR <= 32'h00000000;
         MSI_DATA <= 16'h0000;
         INTX_ASSERT <= 1'b0;
      end else begin
         INTX_ASSERT <= PORT_IRQ && !message_interrupt_on
                        && power_state_field == scfg_pkg::SCFG_D0;
         case (msg_state)
            scfg_pkg::SCFG_MSG_IDLE: begin
               MSI_WR <= 1'b0;
               if (PORT_IRQ && message_interrupt_on && power_state_field == scfg_pkg::SCFG_D0) begin
                  MSI_WR <= 1'b1;
                  MSI_ADDR <= {msg_addr_hi, 2'h0};
                  MSI_DATA <= msg_word;
                  msg_state <= scfg_pkg::SCFG_MSG_SEND;
               end
            end
            scfg_pkg::SCFG_MSG_SEND: begin
               MSI_WR <= 1'b0;
               if (!PORT_IRQ) begin
                  msg_state <= scfg_pkg::SCFG_MSG_IDLE;
               end
            end
            default: begin
               msg_state <= scfg_pkg::SCFG_MSG_IDLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read mux
   always_comb begin
      if (CFG_ADDR == `SCFG_OFF_SUBVEN) begin
         next_rdata = subsystem_vendor_value;
      end else if (CFG_ADDR == `SCFG_OFF_SUBID) begin
         next_rdata = subsystem_identifier_value;
      end else if (CFG_ADDR == `SCFG_OFF_CAP) begin
         next_rdata = {8'h00, ide_mode ? `SCFG_CAP_IDE : `SCFG_CAP_NORM};
      end else if (CFG_ADDR == `SCFG_OFF_INTLN) begin
         next_rdata = {4'h0, CHIPSET_INTERRUPT_PIN_SELECT, interrupt_line_reg};
      end else if (CFG_ADDR == `SCFG_OFF_PTIM) begin
         next_rdata = primary_channel_decode;
      end else if (CFG_ADDR == `SCFG_OFF_STIM) begin
         next_rdata = secondary_channel_decode;
      end else if (CFG_ADDR == `SCFG_OFF_PWRHDR) begin
         next_rdata = {ide_mode ? `SCFG_PNEXT_IDE : `SCFG_PNEXT_NORM, `SCFG_PM_CID};
      end else if (CFG_ADDR == `SCFG_OFF_PWRCAPS) begin
         next_rdata = {ide_mode ? `SCFG_WAKE_IDE : `SCFG_WAKE_NORM, 8'h00, `SCFG_PM_VER};
      end else if (CFG_ADDR == `SCFG_OFF_PWRCTL) begin
         next_rdata = {wake_request_status, 6'h00, wake_request_enable, 4'h0,
                       `SCFG_NO_WAKE_RESET, 1'b0, power_state_field};
      end else if (CFG_ADDR == `SCFG_OFF_MSGHDR) begin
         next_rdata = `SCFG_MSI_HDR;
      end else if (CFG_ADDR == `SCFG_OFF_MSGCTL) begin
         next_rdata = {8'h00, 1'b0, vector_count_enable,
                       ide_mode ? `SCFG_MMC_IDE : `SCFG_MMC_NORM, message_interrupt_on};
      end else if (CFG_ADDR == `SCFG_OFF_MSGADDR) begin
         next_rdata = {msg_addr_hi[13:0], 2'h0};
      end else if (CFG_ADDR == `SCFG_OFF_MSGADDR_HI) begin
         next_rdata = msg_addr_hi[29:14];
      end else if (CFG_ADDR == `SCFG_OFF_MSGDATA) begin
         next_rdata = message_data_value;
      end else begin
         next_rdata = 16'h0000;
      end
   end

   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         CFG_RDATA <= 16'h0000;
      end else if (CFG_RD) begin
         CFG_RDATA <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////
   wake_ide_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      ide_mode |=> !wake_request_status && !wake_request_enable) else $error("wake bits set in IDE");
   pme_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      PME_ASSERT |-> $past(wake_request_status) && $past(wake_request_enable)) else $error("PME without enable");
   wake_sticky_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      WAKE_EVENT && !ide_mode |=> wake_request_status) else $error("wake event lost");
   flr_keep_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      FLR && !ide_mode && !WAKE_EVENT && !wr_ok |=> $stable(wake_request_status)) else $error("FLR hit status");
   message_interrupt_on_ide_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      ide_mode |=> !message_interrupt_on) else $error("MSI on in IDE");
   intx_block_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      INTX_ASSERT |-> !$past(message_interrupt_on)) else $error("pin used with MSI");
   msi_once_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      MSI_WR |=> !MSI_WR) else $error("double message");
   msi_align_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      MSI_WR |-> MSI_ADDR[1:0] == 2'h0) else $error("unaligned address");
   msi_port_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      MSI_WR && $past(vector_count_enable) == 3'h4 |-> MSI_DATA[2:0] == $past(PORT_NUM)) else $error("bad port vector");
   d3_block_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      power_state_field == scfg_pkg::SCFG_D3HOT |=> !INTX_ASSERT && !MSI_WR) else $error("irq in D3hot");
   pme_d3_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      PME_ASSERT |-> $past(power_state_field) == scfg_pkg::SCFG_D3HOT) else $error("PME outside D3hot");
   io_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST)
      IO_MEM_ENABLE |-> $past(power_state_field) == scfg_pkg::SCFG_D0) else $error("IO enabled in D3hot");
endmodule : scfg_regs
`default_nettype wire

// ==== tb/scfg_msi_sink.sv ====
`timescale 1ns/100ps
`default_nettype none
module scfg_msi_sink (
   // Clock and reset
   input wire logic CLK,
   input wire logic SYS_RST,
   // Message write from the controller
   input wire logic MSI_WR,
   input wire logic [31:0] MSI_ADDR,
   input wire logic [15:0] MSI_DATA,
   // Observed traffic
   output logic [7:0] MSG_COUNT,
   output logic [31:0] LAST_ADDR,
   output logic [15:0] LAST_DATA
);
   // Memory target accepts every write at once; counts expose duplicates
   always_ff @(posedge CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         MSG_COUNT <= 8'h00;
         LAST_ADDR <= 32'h00000000;
         LAST_DATA <= 16'h0000;
      end else if (MSI_WR) begin
         MSG_COUNT <= MSG_COUNT + 8'h01;
         LAST_ADDR <= MSI_ADDR;
         LAST_DATA <= MSI_DATA;
      end
   end
endmodule : scfg_msi_sink
`default_nettype wire

// ==== tb/sata_config_pm_msi_regs_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "scfg_consts.svh"
module sata_config_pm_msi_regs_bench;
   logic clk, rst, flr, wr, rd, wake, irq_in, intx, pme, iome, msi_wr;
   logic p_dec, s_dec;
   logic [7:0] addr, storage_subclass_code, msg_count;
   logic [15:0] wdata, rdata, msi_data, last_data;
   logic [3:0] pin_sel;
   logic [2:0] port_num;
   logic [31:0] msi_addr, last_addr;
   int errors, cmp_count;
   ////////////////////////////////////////////////////////////////
   scfg_regs dut (.CLK(clk), .SYS_RST(rst), .FLR(flr), .CFG_WR(wr), .CFG_RD(rd), .CFG_ADDR(addr),
      .CFG_WDATA(wdata), .CFG_RDATA(rdata), .STORAGE_SUBCLASS_CODE(storage_subclass_code),
      .CHIPSET_INTERRUPT_PIN_SELECT(pin_sel), .WAKE_EVENT(wake), .PORT_IRQ(irq_in), .PORT_NUM(port_num),
      .PRIMARY_DECODE_ON(p_dec), .SECONDARY_DECODE_ON(s_dec), .INTX_ASSERT(intx), .PME_ASSERT(pme),
      .IO_MEM_ENABLE(iome), .MSI_WR(msi_wr), .MSI_ADDR(msi_addr), .MSI_DATA(msi_data));
   scfg_msi_sink sink (.CLK(clk), .SYS_RST(rst), .MSI_WR(msi_wr), .MSI_ADDR(msi_addr), .MSI_DATA(msi_data),
      .MSG_COUNT(msg_count), .LAST_ADDR(last_addr), .LAST_DATA(last_data));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
   endtask : wr_reg
   // Sample a cycle and a half after the read edge, data stands until next read
   task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
      @(negedge clk);
      rd = 1'b1;
      addr = a;
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      chk(rdata, exp);
   endtask : rd_chk
   // Level held four cycles must still give a single message
   task automatic irq(input logic [2:0] p);
      @(negedge clk);
      port_num = p;
      irq_in = 1'b1;
      repeat (4) @(negedge clk);
      irq_in = 1'b0;
      repeat (2) @(negedge clk);
   endtask : irq
   task automatic final_report;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #200000;
      errors++;
      final_report();
   end
   initial begin
      {flr, wr, rd, wake, irq_in} = 5'h00;
      addr = 8'h00;
      wdata = 16'h0000;
      port_num = 3'h0;
      pin_sel = 4'h1;
      storage_subclass_code = 8'h06;
      errors = 0;
      cmp_count = 0;
      rst = 1'b1;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      chk(iome, 1'b1);
      rd_chk(`SCFG_OFF_MSGHDR, 16'h7005);
      rd_chk(`SCFG_OFF_CAP, 16'h0080);
      rd_chk(`SCFG_OFF_INTLN, 16'h0100);
      rd_chk(`SCFG_OFF_PWRHDR, 16'hA801);
      rd_chk(`SCFG_OFF_PWRCAPS, 16'h4003);
      rd_chk(`SCFG_OFF_PWRCTL, 16'h0008);
      rd_chk(`SCFG_OFF_MSGCTL, 16'h0008);
      rd_chk(8'hF0, 16'h0000);
      // Second write of the ids must be dropped
      wr_reg(`SCFG_OFF_SUBVEN, 16'hC3A5);
      wr_reg(`SCFG_OFF_SUBVEN, 16'h0000);
      rd_chk(`SCFG_OFF_SUBVEN, 16'hC3A5);
      wr_reg(`SCFG_OFF_SUBID, 16'h1234);
      wr_reg(`SCFG_OFF_SUBID, 16'h5678);
      rd_chk(`SCFG_OFF_SUBID, 16'h1234);
      wr_reg(`SCFG_OFF_PTIM, 16'h8000);
      @(negedge clk);
      chk({p_dec, s_dec}, 2'h2);
      wr_reg(`SCFG_OFF_STIM, 16'h8000);
      @(negedge clk);
      chk({p_dec, s_dec}, 2'h3);
      // Wake path from D3hot
      wr_reg(`SCFG_OFF_PWRCTL, 16'h0103);
      @(negedge clk);
      chk(iome, 1'b0);
      // Port request in D3hot must not reach the pin
      irq_in = 1'b1;
      repeat (2) @(negedge clk);
      chk(intx, 1'b0);
      irq_in = 1'b0;
      wake = 1'b1;
      @(negedge clk);
      wake = 1'b0;
      repeat (2) @(negedge clk);
      chk(pme, 1'b1);
      rd_chk(`SCFG_OFF_PWRCTL, 16'h810B);
      flr = 1'b1;
      @(negedge clk);
      flr = 1'b0;
      rd_chk(`SCFG_OFF_PWRCTL, 16'h8108);
      chk(pme, 1'b0);
      wr_reg(`SCFG_OFF_PWRCTL, 16'h8100);
      rd_chk(`SCFG_OFF_PWRCTL, 16'h0108);
      wr_reg(`SCFG_OFF_PWRCTL, 16'h0000);
      // Pin interrupt while messages are off
      @(negedge clk);
      irq_in = 1'b1;
      repeat (2) @(negedge clk);
      chk(intx, 1'b1);
      irq_in = 1'b0;
      repeat (2) @(negedge clk);
      wr_reg(`SCFG_OFF_MSGADDR, 16'h1237);
      wr_reg(`SCFG_OFF_MSGADDR_HI, 16'hABCD);
      wr_reg(`SCFG_OFF_MSGDATA, 16'h5A5F);
      rd_chk(`SCFG_OFF_MSGADDR, 16'h1234);
      wr_reg(`SCFG_OFF_MSGCTL, 16'h0001);
      irq(3'h5);
      chk(msg_count, 8'h01);
      chk(last_addr, 32'hABCD1234);
      chk(last_data, 16'h5A5F);
      chk(intx, 1'b0);
      wr_reg(`SCFG_OFF_MSGCTL, 16'h0000);
      wr_reg(`SCFG_OFF_MSGCTL, 16'h0041);
      for (int p = 0; p < 6; p++) begin
         irq(p[2:0]);
         chk(msg_count, 8'(p + 2));
         chk(last_data, {13'h0B4B, p[2:0]});
      end
      // Leave message mode before entering IDE
      wr_reg(`SCFG_OFF_MSGCTL, 16'h0000);
      @(negedge clk);
      storage_subclass_code = `SCFG_SUBCLASS_IDE;
      rd_chk(`SCFG_OFF_CAP, 16'h0070);
      rd_chk(`SCFG_OFF_PWRHDR, 16'hB001);
      rd_chk(`SCFG_OFF_PWRCAPS, 16'h0003);
      wr_reg(`SCFG_OFF_PWRCTL, 16'h0100);
      rd_chk(`SCFG_OFF_PWRCTL, 16'h0008);
      wr_reg(`SCFG_OFF_MSGCTL, 16'h0001);
      rd_chk(`SCFG_OFF_MSGCTL, 16'h0000);
      final_report();
   end
endmodule : sata_config_pm_msi_regs_bench
`default_nettype wire
